// >>> hdl/cdsr_pkg.sv
/*
 Register indices, bit positions, constants and
 carrier structs of the status and calibration block.
 Assumes a single clock domain and 16-bit register words throughout.
*/
package cdsr_pkg;

    // Register indices on the programming port (arbitrary choice)
    localparam logic [3:0] IDX_FAULT_STATUS    = 4'h0;
    localparam logic [3:0] IDX_PROG_STATUS     = 4'h1;
    localparam logic [3:0] IDX_MAKER_TRACE_1   = 4'h2;
    localparam logic [3:0] IDX_MAKER_TRACE_2   = 4'h3;
    localparam logic [3:0] IDX_USER_TAG_1      = 4'h4;
    localparam logic [3:0] IDX_USER_TAG_2      = 4'h5;
    localparam logic [3:0] IDX_PHASE_CORR      = 4'h6;
    localparam logic [3:0] IDX_FIRST_SCALE     = 4'h7;
    localparam logic [3:0] IDX_SECOND_SCALE    = 4'h8;
    localparam logic [3:0] IDX_POLY_A          = 4'h9;
    localparam logic [3:0] IDX_POLY_B          = 4'hA;
    localparam logic [3:0] IDX_POLY_C          = 4'hB;
    localparam logic [3:0] IDX_WEIGHT_FIRST    = 4'hC;
    localparam logic [3:0] IDX_WEIGHT_SECOND   = 4'hD;

    // Fault status bit positions
    localparam int FS_CLAMP_HIGH  = 9;
    localparam int FS_CLAMP_LOW   = 8;
    localparam int FS_CLIP_FIRST  = 7;
    localparam int FS_CLIP_SECOND = 6;
    localparam int FS_PROC_TEST   = 5;
    localparam int FS_MEM_TEST    = 4;
    localparam int FS_PARITY      = 3;
    localparam int FS_FIELD_HIGH  = 1;
    localparam int FS_FIELD_LOW   = 0;
    localparam logic [15:0] FS_USED_MASK = 16'h03FB;

    // Programming status bit positions
    localparam int PS_PUMP_ERR    = 10;
    localparam int PS_SUPPLY_ERR  = 9;
    localparam int PS_WRITE_ERR   = 8;
    localparam logic [15:0] PS_CTRL_MASK = 16'h003F;

    // Reset values and scaling shifts
    localparam logic [15:0] UNITY_GAIN   = 16'h4000;
    localparam logic [15:0] ZERO_WORD    = 16'h0000;
    localparam int          GAIN_SHIFT   = 14;
    localparam int          Q15_SHIFT    = 15;
    localparam int          TEMP_SHIFT   = 15;

    // Identification defaults; values are arbitrary
    localparam logic [15:0] MAKER_TRACE_1_DEF = 16'h1234;
    localparam logic [15:0] MAKER_TRACE_2_DEF = 16'h5678;

    // Fault event inputs from the surrounding processor
    typedef struct packed {
        logic clip_first;
        logic clip_second;
        logic proc_test_fail;
        logic mem_test_fail;
        logic parity_fail;
        logic pump_low;
        logic supply_low;
        logic write_fail;
    } cdsr_events_t;

    // Calibration coefficients handed to the datapath
    typedef struct packed {
        logic signed [15:0] phase;
        logic signed [15:0] gain_first;
        logic signed [15:0] gain_second;
        logic signed [15:0] poly_a;
        logic signed [15:0] poly_b;
        logic signed [15:0] poly_c;
        logic signed [15:0] weight_first;
        logic signed [15:0] weight_second;
    } cdsr_coef_t;

endpackage

// >>> hdl/cdsr_range_check.sv
/*
 Field window and output clamp comparator.
 Assumes amplitude, limits and output code are sampled on CLOCK.
*/
`timescale 1ns/10ps
`default_nettype none
module cdsr_range_check
    import cdsr_pkg::*;
(
    // Clock and reset
    input  wire logic               clk,
    input  wire logic               rst,
    // Compared values
    input  wire logic signed [15:0] amplitude,
    input  wire logic signed [15:0] field_upper_limit,
    input  wire logic signed [15:0] field_lower_limit,
    input  wire logic        [15:0] out_code,
    input  wire logic        [15:0] clamp_high,
    input  wire logic        [15:0] clamp_low,
    // Level results, registered
    output logic                    field_too_high_flag,
    output logic                    field_too_low_flag,
    output logic                    at_clamp_high,
    output logic                    at_clamp_low
);
    logic next_high;     // Next field-high
    logic next_low;      // Next field-low
    logic next_chigh;    // Next clamp-high
    logic next_clow;     // Next clamp-low

    // Compare all four thresholds each cycle
    always_comb begin
        next_high  = amplitude > field_upper_limit;
        next_low   = amplitude < field_lower_limit;
        next_chigh = out_code >= clamp_high;
        next_clow  = out_code <= clamp_low;
    end

    // Register results
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            field_too_high_flag <= 1'b0;
            field_too_low_flag  <= 1'b0;
            at_clamp_high       <= 1'b0;
            at_clamp_low        <= 1'b0;
        end else begin
            field_too_high_flag <= next_high;
            field_too_low_flag  <= next_low;
            at_clamp_high       <= next_chigh;
            at_clamp_low        <= next_clow;
        end
    end
endmodule
`default_nettype wire

// >>> hdl/cdsr_channel_cal.sv
/*
 Per-channel gain and weighted offset stage.
 Assumes Q14 gain, Q15 weight and one-cycle registered output.
*/
`timescale 1ns/10ps
`default_nettype none
module cdsr_channel_cal
    import cdsr_pkg::*;
(
    // Clock and reset
    input  wire logic               clk,
    input  wire logic               rst,
    // Input sample and its coefficients
    input  wire logic signed [15:0] sample,
    input  wire logic signed [15:0] gain,
    input  wire logic signed [15:0] weight,
    input  wire logic signed [15:0] user_offset,
    // Corrected sample
    output logic signed [15:0]      result
);
    logic signed [31:0] scaled;     // Gain product
    logic signed [31:0] offs;       // Weighted offset product
    logic signed [17:0] sum;        // Wide sum before saturation
    logic signed [15:0] next_result;

    // Gain, weight and saturate
    always_comb begin
        scaled = sample * gain;
        offs   = user_offset * weight;
        sum    = 18'(scaled >>> GAIN_SHIFT)
               + 18'(offs >>> Q15_SHIFT);
        // Saturate so a large gain cannot wrap the sign
        if (sum > 18'sd32767)
            next_result = 16'sh7FFF;
        else if (sum < -18'sd32768)
            next_result = 16'sh8000;
        else
            next_result = sum[15:0];
    end

    // Register result
    always_ff @(posedge clk or posedge rst) begin
        if (rst)
            result <= '0;
        else
            result <= next_result;
    end
endmodule
`default_nettype wire

// >>> hdl/cdsr_top.sv
/*
 Status words, ID words and calibration registers
 of a two-channel field sensor processor,
 with phase, gain and offset correction.
 Assumes a programming port decoded elsewhere,
 with one-cycle strobes,
 and fault events as one-cycle pulses.

*/
`timescale 1ns/10ps
`default_nettype none
module cdsr_top
    import cdsr_pkg::*;
(
    // Clock and reset
    input  wire logic               CLOCK,
    input  wire logic               RST,
    // Programming register port
    input  wire logic               REG_WR,
    input  wire logic               REG_RD,
    input  wire logic        [3:0]  REG_ADDR,
    input  wire logic        [15:0] REG_WDATA,
    output logic             [15:0] REG_RDATA,
    output logic                    REG_ACK,
    // Options and limits from setup memory
    input  wire logic               DIAG_LATCH_EN,
    input  wire logic               LOCK,
    input  wire logic signed [15:0] FIELD_UPPER_LIMIT,
    input  wire logic signed [15:0] FIELD_LOWER_LIMIT,
    input  wire logic        [15:0] CLAMP_HIGH,
    input  wire logic        [15:0] CLAMP_LOW,
    // Fault events
    input  wire cdsr_events_t       EVENTS,
    // Signal path
    input  wire logic               SAMPLE_VALID,
    input  wire logic signed [15:0] FIRST_CHANNEL_IN,
    input  wire logic signed [15:0] SECOND_CHANNEL_IN,
    input  wire logic        [15:0] JUNCTION_TEMP,
    input  wire logic signed [15:0] AMPLITUDE,
    input  wire logic        [15:0] OUT_CODE,
    output logic signed [15:0]      FIRST_CHANNEL_OUT,
    output logic signed [15:0]      SECOND_CHANNEL_OUT,
    output logic                    OUT_VALID,
    output logic                    FORCE_HIGH_CLAMP,
    output logic             [15:0] FAULT_STATUS
);

    // Calibration and ID registers
    cdsr_coef_t  coef;           // Calibration coefficients
    cdsr_coef_t  next_coef;
    logic [15:0] user_tag_word_1;
    logic [15:0] user_tag_word_2;
    logic [15:0] next_tag_1;
    logic [15:0] next_tag_2;
    logic [15:0] maker_trace_word_1;  // Fixed, never writable
    logic [15:0] maker_trace_word_2;

    // Status words
    logic [15:0] fault_status;
    logic [15:0] next_fault;
    logic [15:0] program_fault_status;
    logic [15:0] next_prog;

    // Read port
    logic [15:0] next_rdata;
    logic        next_ack;

    // Range results
    logic field_too_high_flag;
    logic field_too_low_flag;
    logic at_clamp_high;
    logic at_clamp_low;

    // Datapath pipeline
    logic signed [15:0] user_offset;
    logic signed [15:0] next_user_offset;
    logic signed [15:0] second_phased;
    logic signed [15:0] next_second_phased;
    logic signed [15:0] first_d;
    logic signed [15:0] next_first_d;
    logic        [1:0]  valid_pipe;
    logic        [1:0]  next_valid_pipe;

    // Helpers
    logic signed [16:0] temp_s;     // Temperature as signed
    logic signed [33:0] t_sq;
    logic signed [33:0] poly;
    logic signed [31:0] phase_prod;
    logic signed [17:0] phase_sum;
    logic               wr_ok;

    assign maker_trace_word_1 = MAKER_TRACE_1_DEF;
    assign maker_trace_word_2 = MAKER_TRACE_2_DEF;

    // Window and clamp comparators
    cdsr_range_check u_range (
        .clk                 (CLOCK),
        .rst                 (RST),
        .amplitude           (AMPLITUDE),
        .field_upper_limit   (FIELD_UPPER_LIMIT),
        .field_lower_limit   (FIELD_LOWER_LIMIT),
        .out_code            (OUT_CODE),
        .clamp_high          (CLAMP_HIGH),
        .clamp_low           (CLAMP_LOW),
        .field_too_high_flag (field_too_high_flag),
        .field_too_low_flag  (field_too_low_flag),
        .at_clamp_high       (at_clamp_high),
        .at_clamp_low        (at_clamp_low)
    );

    // Register writes; lock freezes everything the programmer may write
    always_comb begin
        wr_ok      = REG_WR && !LOCK;
        next_coef  = coef;
        next_tag_1 = user_tag_word_1;
        next_tag_2 = user_tag_word_2;
        if (wr_ok) begin
            if (REG_ADDR == IDX_USER_TAG_1) begin
                next_tag_1 = REG_WDATA;
            end else if (REG_ADDR == IDX_USER_TAG_2) begin
                next_tag_2 = REG_WDATA;
            end else if (REG_ADDR == IDX_PHASE_CORR) begin
                next_coef.phase = REG_WDATA;
            end else if (REG_ADDR == IDX_FIRST_SCALE) begin
                next_coef.gain_first = REG_WDATA;
            end else if (REG_ADDR == IDX_SECOND_SCALE) begin
                next_coef.gain_second = REG_WDATA;
            end else if (REG_ADDR == IDX_POLY_A) begin
                next_coef.poly_a = REG_WDATA;
            end else if (REG_ADDR == IDX_POLY_B) begin
                next_coef.poly_b = REG_WDATA;
            end else if (REG_ADDR == IDX_POLY_C) begin
                next_coef.poly_c = REG_WDATA;
            end else if (REG_ADDR == IDX_WEIGHT_FIRST) begin
                next_coef.weight_first = REG_WDATA;
            end else if (REG_ADDR == IDX_WEIGHT_SECOND) begin
                next_coef.weight_second = REG_WDATA;
            end
        end
    end

    // Status words: event bits sticky, set wins over a same-cycle clear
    always_comb begin
        next_fault = fault_status;
        // Live conditions follow their cause
        next_fault[FS_CLAMP_HIGH] = at_clamp_high;
        next_fault[FS_CLAMP_LOW]  = at_clamp_low;
        next_fault[FS_FIELD_HIGH] = field_too_high_flag;
        next_fault[FS_FIELD_LOW]  = field_too_low_flag;
        // Clip and self-test results latch until reset
        if (EVENTS.clip_first)
            next_fault[FS_CLIP_FIRST] = 1'b1;
        if (EVENTS.clip_second)
            next_fault[FS_CLIP_SECOND] = 1'b1;
        if (EVENTS.proc_test_fail)
            next_fault[FS_PROC_TEST] = 1'b1;
        if (EVENTS.mem_test_fail && DIAG_LATCH_EN)
            next_fault[FS_MEM_TEST] = 1'b1;
        if (EVENTS.parity_fail)
            next_fault[FS_PARITY] = 1'b1;
        next_fault = next_fault & FS_USED_MASK;

        // Programming word: error bits sticky, low six written
        next_prog = program_fault_status;
        if (wr_ok && REG_ADDR == IDX_PROG_STATUS) begin
            // Writing a one clears an error bit
            next_prog = (program_fault_status & ~REG_WDATA)
                      & ~PS_CTRL_MASK;
            next_prog = next_prog | (REG_WDATA & PS_CTRL_MASK);
        end
        if (EVENTS.pump_low)
            next_prog[PS_PUMP_ERR] = 1'b1;
        if (EVENTS.supply_low)
            next_prog[PS_SUPPLY_ERR] = 1'b1;
        if (EVENTS.write_fail)
            next_prog[PS_WRITE_ERR] = 1'b1;
        next_prog[15:11] = 5'h00;
        next_prog[7:6]   = 2'h0;
    end

    // Read mux, one cycle after the strobe
    always_comb begin
        next_ack   = REG_RD;
        next_rdata = ZERO_WORD;
        if (REG_ADDR == IDX_FAULT_STATUS)
            next_rdata = fault_status;
        else if (REG_ADDR == IDX_PROG_STATUS)
            next_rdata = program_fault_status;
        else if (REG_ADDR == IDX_MAKER_TRACE_1)
            next_rdata = maker_trace_word_1;
        else if (REG_ADDR == IDX_MAKER_TRACE_2)
            next_rdata = maker_trace_word_2;
        else if (REG_ADDR == IDX_USER_TAG_1)
            next_rdata = user_tag_word_1;
        else if (REG_ADDR == IDX_USER_TAG_2)
            next_rdata = user_tag_word_2;
        else if (REG_ADDR == IDX_PHASE_CORR)
            next_rdata = coef.phase;
        else if (REG_ADDR == IDX_FIRST_SCALE)
            next_rdata = coef.gain_first;
        else if (REG_ADDR == IDX_SECOND_SCALE)
            next_rdata = coef.gain_second;
        else if (REG_ADDR == IDX_POLY_A)
            next_rdata = coef.poly_a;
        else if (REG_ADDR == IDX_POLY_B)
            next_rdata = coef.poly_b;
        else if (REG_ADDR == IDX_POLY_C)
            next_rdata = coef.poly_c;
        else if (REG_ADDR == IDX_WEIGHT_FIRST)
            next_rdata = coef.weight_first;
        else if (REG_ADDR == IDX_WEIGHT_SECOND)
            next_rdata = coef.weight_second;
        if (!REG_RD)
            next_rdata = REG_RDATA;   // Hold last read value
    end

    // Stage one: offset polynomial and phase correction
    always_comb begin
        temp_s = {1'b0, JUNCTION_TEMP};
        t_sq   = 34'((34'(temp_s) * 34'(temp_s)) >>> TEMP_SHIFT);
        // Offset = a + b*T + c*T^2, T scaled to Q15
        poly   = 34'(coef.poly_a)
               + 34'((34'(coef.poly_b) * 34'(temp_s)) >>> TEMP_SHIFT)
               + 34'((34'(coef.poly_c) * t_sq) >>> TEMP_SHIFT);
        if (poly > 34'sd32767)
            next_user_offset = 16'sh7FFF;
        else if (poly < -34'sd32768)
            next_user_offset = 16'sh8000;
        else
            next_user_offset = poly[15:0];
        // Second channel gains a share of the first by sin(phase)
        phase_prod = FIRST_CHANNEL_IN * coef.phase;
        phase_sum  = 18'(SECOND_CHANNEL_IN)
                   + 18'(phase_prod >>> Q15_SHIFT);
        if (phase_sum > 18'sd32767)
            next_second_phased = 16'sh7FFF;
        else if (phase_sum < -18'sd32768)
            next_second_phased = 16'sh8000;
        else
            next_second_phased = phase_sum[15:0];
        next_first_d    = FIRST_CHANNEL_IN;
        next_valid_pipe = {valid_pipe[0], SAMPLE_VALID};
    end

    // Register state
    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            coef.phase           <= ZERO_WORD;
            coef.gain_first      <= UNITY_GAIN;
            coef.gain_second     <= UNITY_GAIN;
            coef.poly_a          <= ZERO_WORD;
            coef.poly_b          <= ZERO_WORD;
            coef.poly_c          <= ZERO_WORD;
            coef.weight_first    <= ZERO_WORD;
            coef.weight_second   <= ZERO_WORD;
            user_tag_word_1      <= ZERO_WORD;
            user_tag_word_2      <= ZERO_WORD;
            fault_status         <= ZERO_WORD;
            program_fault_status <= ZERO_WORD;
            REG_RDATA            <= ZERO_WORD;
            REG_ACK              <= 1'b0;
            user_offset          <= '0;
            second_phased        <= '0;
            first_d              <= '0;
            valid_pipe           <= 2'h0;
        end else begin
            coef                 <= next_coef;
            user_tag_word_1      <= next_tag_1;
            user_tag_word_2      <= next_tag_2;
            fault_status         <= next_fault;
            program_fault_status <= next_prog;
            REG_RDATA            <= next_rdata;
            REG_ACK              <= next_ack;
            user_offset          <= next_user_offset;
            second_phased        <= next_second_phased;
            first_d              <= next_first_d;
            valid_pipe           <= next_valid_pipe;
        end
    end

    // Stage two: gain and weighted offset per channel
    cdsr_channel_cal u_cal_first (
        .clk         (CLOCK),
        .rst         (RST),
        .sample      (first_d),
        .gain        (coef.gain_first),
        .weight      (coef.weight_first),
        .user_offset (user_offset),
        .result      (FIRST_CHANNEL_OUT)
    );

    cdsr_channel_cal u_cal_second (
        .clk         (CLOCK),
        .rst         (RST),
        .sample      (second_phased),
        .gain        (coef.gain_second),
        .weight      (coef.weight_second),
        .user_offset (user_offset),
        .result      (SECOND_CHANNEL_OUT)
    );

    // Outputs
    assign OUT_VALID        = valid_pipe[1];
    assign FORCE_HIGH_CLAMP = field_too_high_flag
                            | field_too_low_flag;
    assign FAULT_STATUS     = fault_status;

endmodule
`default_nettype wire

// >>> tb/cdsr_top_properties.sv
/* Port checker for cdsr_top: status bits, read answer, clamp force.
 Assumes one CLOCK domain with RST asynchronous, active high. */
`timescale 1ns/10ps
`default_nettype none
module cdsr_top_properties
    import cdsr_pkg::*;
(
    // Clock, reset and read handshake
    input  wire logic               CLOCK,
    input  wire logic               RST,
    input  wire logic               REG_RD,
    input  wire logic               REG_ACK,
    // Status causes and results
    input  wire logic               DIAG_LATCH_EN,
    input  wire logic signed [15:0] FIELD_UPPER_LIMIT,
    input  wire logic signed [15:0] FIELD_LOWER_LIMIT,
    input  wire logic        [15:0] CLAMP_HIGH,
    input  wire logic        [15:0] CLAMP_LOW,
    input  wire cdsr_events_t       EVENTS,
    input  wire logic               SAMPLE_VALID,
    input  wire logic signed [15:0] AMPLITUDE,
    input  wire logic        [15:0] OUT_CODE,
    input  wire logic               OUT_VALID,
    input  wire logic               FORCE_HIGH_CLAMP,
    input  wire logic        [15:0] FAULT_STATUS
);
    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (RST);
    chk_ack_timing: assert property (REG_RD |=> REG_ACK)
        else $error("read not answered");
    chk_reserved_zero: assert property (
        {FAULT_STATUS[15:10], FAULT_STATUS[2]} == 7'h00)
        else $error("reserved status bit set");
    // Two-cycle lag, so two clean edges must lie behind the check
    chk_clamp_bits: assert property (
        !$past(RST) && !$past(RST, 2) |-> FAULT_STATUS[9:8] ==
        {$past(OUT_CODE >= CLAMP_HIGH, 2), $past(OUT_CODE <= CLAMP_LOW, 2)})
        else $error("clamp bits wrong");
    chk_field_bits: assert property (
        !$past(RST) && !$past(RST, 2) |-> FAULT_STATUS[1:0] ==
        {$past(AMPLITUDE > FIELD_UPPER_LIMIT, 2),
         $past(AMPLITUDE < FIELD_LOWER_LIMIT, 2)})
        else $error("field window bits wrong");
    chk_force_clamp: assert property (
        !$past(RST) |-> FORCE_HIGH_CLAMP == $past(AMPLITUDE >
        FIELD_UPPER_LIMIT || AMPLITUDE < FIELD_LOWER_LIMIT))
        else $error("upper clamp force wrong");
    chk_clip_sticky: assert property (
        EVENTS.clip_first |=> FAULT_STATUS[7] [*4])
        else $error("first clip bit not held");
    chk_clip_second: assert property (
        EVENTS.clip_second |=> FAULT_STATUS[6])
        else $error("second clip bit not set");
    chk_proc_test: assert property (
        EVENTS.proc_test_fail |=> FAULT_STATUS[5])
        else $error("processor test bit not set");
    chk_mem_gate: assert property (
        $rose(FAULT_STATUS[4]) |->
        $past(EVENTS.mem_test_fail && DIAG_LATCH_EN))
        else $error("memory test bit set without cause");
    chk_parity_bit: assert property (
        EVENTS.parity_fail |=> FAULT_STATUS[3])
        else $error("parity bit not set");
    chk_out_valid: assert property (SAMPLE_VALID |=> ##1 OUT_VALID)
        else $error("output valid late");
endmodule
bind cdsr_top cdsr_top_properties cdsr_top_properties_i (.*);
`default_nettype wire

// >>> tb/cdsr_prog_model.sv
/* End-of-line programmer model: one-cycle register strobes.
 Assumes requests launch 2 ns after a rising edge of clk. */
`timescale 1ns/10ps
`default_nettype none
module cdsr_prog_model (
    // Clock and device answer
    input  wire logic        clk,
    input  wire logic [15:0] rdata,
    input  wire logic        ack,
    // Requests toward the device
    output var  logic        wr,
    output var  logic        rd,
    output var  logic [3:0]  addr,
    output var  logic [15:0] wdata
);
    initial {wr, rd, addr, wdata} = {2'b00, 4'hF, 16'hA5A5};
    // Released lines show inverted values, never a stale copy
    task automatic xfer(input logic w, input logic [3:0] a,
                        input logic [15:0] d, output logic [15:0] q,
                        output logic ok);
        @(posedge clk);
        #2;
        {wr, rd, addr, wdata} = {w, !w, a, d};
        @(posedge clk);
        #2;
        {wr, rd, addr, wdata} = {2'b00, ~a, ~d};
        ok = ack;
        q = rdata;
    endtask
endmodule
`default_nettype wire

// >>> tb/testbench.sv
/* Self-checking bench for cdsr_top.
 Assumes 40 MHz CLOCK, inputs driven 2 ns after each edge. */
`timescale 1ns/10ps
`default_nettype none
module testbench import cdsr_pkg::*;;
    logic               CLOCK, RST, DIAG_LATCH_EN, LOCK, SAMPLE_VALID, ok;
    logic               REG_WR, REG_RD, REG_ACK, OUT_VALID, FORCE_HIGH_CLAMP;
    logic        [3:0]  REG_ADDR;
    logic        [15:0] REG_WDATA, REG_RDATA, CLAMP_HIGH, CLAMP_LOW, OUT_CODE;
    logic        [15:0] JUNCTION_TEMP, FAULT_STATUS, q, st, p;
    logic signed [15:0] FIELD_UPPER_LIMIT, FIELD_LOWER_LIMIT, AMPLITUDE;
    logic signed [15:0] FIRST_CHANNEL_IN, SECOND_CHANNEL_IN, cf [14];
    logic signed [15:0] FIRST_CHANNEL_OUT, SECOND_CHANNEL_OUT;
    cdsr_events_t       EVENTS;
    longint             ph;
    int                 fail_count = 0, cmp_count = 0, cycles = 0;
    cdsr_top cdsr_top_i (.*);
    cdsr_prog_model prog_i (.clk(CLOCK), .rdata(REG_RDATA), .ack(REG_ACK),
        .wr(REG_WR), .rd(REG_RD), .addr(REG_ADDR), .wdata(REG_WDATA));
    always #12.5 CLOCK = ~CLOCK;
    // Ceiling far above the roughly 130 cycles the run needs
    always @(posedge CLOCK) begin
        cycles++;
        if (cycles == 20000) begin
            fail_count++;
            print_verdict();
        end
    end
    task automatic cmp(input logic [15:0] got, exp, input string s);
        cmp_count++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED %0t %s got %h exp %h", $time, s, got, exp);
        end
    endtask
    task automatic print_verdict();
        $display("compares %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        prog_i.xfer(1'b1, a, d, q, ok);
    endtask
    // Read through the programmer; acknowledge always expected
    task automatic rdc(input logic [3:0] a, input logic [15:0] e);
        prog_i.xfer(1'b0, a, 16'h0000, q, ok);
        cmp({15'h0000, ok}, 16'h0001, "ack");
        cmp(q, e, "read data");
    endtask
    task automatic pulse(input logic [7:0] e);
        @(posedge CLOCK);
        #2;
        EVENTS = e;
        @(posedge CLOCK);
        #2;
        EVENTS = '0;
    endtask
    task automatic settle();
        repeat (3) @(posedge CLOCK);
        #2;
    endtask
    function automatic logic [15:0] sat(input longint v);
        return (v > 32767) ? 16'h7FFF : (v < -32768) ? 16'h8000 : v[15:0];
    endfunction
    function automatic logic [15:0] cal(input longint x, g, w, o);
        return sat(((x * g) >>> 14) + ((o * w) >>> 15));
    endfunction
    function automatic longint user_offset();
        longint t = JUNCTION_TEMP;
        return $signed(sat(cf[9] + ((cf[10] * t) >>> 15)
                       + ((cf[11] * ((t * t) >>> 15)) >>> 15)));
    endfunction
    initial begin
        {CLOCK, RST, DIAG_LATCH_EN, LOCK, SAMPLE_VALID, EVENTS} = 13'h0800;
        {FIELD_UPPER_LIMIT, FIELD_LOWER_LIMIT} = {16'sh4000, 16'sh1000};
        {CLAMP_HIGH, CLAMP_LOW} = {16'h7000, 16'h0100};
        {OUT_CODE, AMPLITUDE, JUNCTION_TEMP} = {16'h2000, 16'sh2000, 16'h0};
        {FIRST_CHANNEL_IN, SECOND_CHANNEL_IN, st} = '0;
        void'($urandom(32'h677B3B45));
        repeat (2) @(posedge CLOCK);
        #2;
        RST = 1'b0;
        // Reset image, read-only places and an unmapped index
        rdc(IDX_PHASE_CORR, ZERO_WORD);
        rdc(IDX_FIRST_SCALE, UNITY_GAIN);
        wr(IDX_MAKER_TRACE_2, 16'hFFFF);
        rdc(IDX_MAKER_TRACE_2, MAKER_TRACE_2_DEF);
        rdc(IDX_MAKER_TRACE_1, MAKER_TRACE_1_DEF);
        wr(IDX_FAULT_STATUS, 16'hFFFF);
        rdc(IDX_FAULT_STATUS, 16'h0000);
        rdc(4'hF, ZERO_WORD);
        // Small random coefficients keep the sums clear of saturation
        for (int i = 4; i < 14; i++) begin
            cf[i] = 16'($urandom_range(4095)) - 16'sd2048;
            cf[i] = (i == 7 || i == 8) ? cf[i] + 16'sh4000 : cf[i];
            if (i == 8)
                cf[i] = 16'($rtoi(16384.0 / $cos($asin(cf[6] / 32768.0))));
            cf[i] = (i > 11) ? 16'($urandom_range(32767)) : cf[i];
            wr(4'(i), cf[i]);
            rdc(4'(i), cf[i]);
        end
        JUNCTION_TEMP = 16'($urandom_range(32767));
        for (int n = 0; n < 8; n++) begin
            @(posedge CLOCK);
            #2;
            FIRST_CHANNEL_IN = 16'($urandom_range(16383)) - 16'sd8192;
            SECOND_CHANNEL_IN = 16'($urandom_range(16383)) - 16'sd8192;
            SAMPLE_VALID = 1'b1;
            ph = SECOND_CHANNEL_IN + ((FIRST_CHANNEL_IN * cf[6]) >>> 15);
            @(posedge CLOCK);
            #2;
            SAMPLE_VALID = 1'b0;
            repeat (2) @(posedge CLOCK);
            #2;
            cmp(FIRST_CHANNEL_OUT, cal(FIRST_CHANNEL_IN, cf[7], cf[12],
                user_offset()), "first out");
            cmp(SECOND_CHANNEL_OUT, cal(ph, cf[8], cf[13], user_offset()),
                "second out");
        end
        // Memory test stays silent until latching is enabled
        pulse(8'h10);
        cmp(FAULT_STATUS, 16'h0000, "unlatched");
        DIAG_LATCH_EN = 1'b1;
        for (int b = 3; b < 8; b++) begin
            pulse(8'(1 << b));
            st = st | 16'(1 << b);
            cmp(FAULT_STATUS, st, "event bit");
        end
        p = 16'($urandom_range(63));
        wr(IDX_PROG_STATUS, 16'hF8C0 | p);
        rdc(IDX_PROG_STATUS, p);
        pulse(8'h07);
        rdc(IDX_PROG_STATUS, 16'h0700 | p);
        wr(IDX_PROG_STATUS, 16'h0100 | p);
        rdc(IDX_PROG_STATUS, 16'h0600 | p);
        // One code past each limit, output sitting on each clamp
        {AMPLITUDE, OUT_CODE} = {16'sh4001, CLAMP_HIGH};
        settle();
        cmp(FAULT_STATUS & 16'h0303, 16'h0202, "high side");
        cmp({15'h0, FORCE_HIGH_CLAMP}, 16'h0001, "force high");
        {AMPLITUDE, OUT_CODE} = {16'sh0FFF, CLAMP_LOW};
        settle();
        cmp(FAULT_STATUS & 16'h0303, 16'h0101, "low side");
        cmp({15'h0, FORCE_HIGH_CLAMP}, 16'h0001, "force low");
        LOCK = 1'b1;
        wr(IDX_USER_TAG_1, ~cf[4]);
        rdc(IDX_USER_TAG_1, cf[4]);
        RST = 1'b1;
        @(posedge CLOCK);
        #2;
        RST = 1'b0;
        cmp(FAULT_STATUS, 16'h0000, "second reset");
        settle();
        print_verdict();
    end
endmodule
`default_nettype wire
